// ### dsg_security_gate.sv
module dsg_security_gate
   import dsg_pkg::*;
(
   input  wire logic          i_clk_sys,
   input  wire logic          i_rst_n,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic              o_pready,
   output logic [31:0]       o_prdata,
   output logic              o_pslverr,
   // pins, synchronised here
   input  wire logic          i_special_mode,
   input  wire logic          i_scan_mode,
   input  wire logic          i_burnin_bypass,
   // same-domain inputs
   input  wire logic          i_opt_load,
   input  wire logic [7:0]    i_opt_byte,
   input  wire logic [1:0]    i_pc_top,
   input  wire logic [15:0]   i_fetch_addr,
   input  wire logic          i_fetch_valid,
   input  wire logic          i_sector_protected,
   input  wire dsg_dbg_req_t  i_dbg_req,
   input  wire logic [15:0]   i_nvm_erase_addr,
   input  wire logic          i_nvm_erase_sector,
   // outputs
   output dsg_dbg_gate_t     o_dbg_gate,
   output logic              o_dbg_port_active,
   output logic              o_trace_enable,
   output logic              o_visibility_en,
   output logic              o_pipe_status_en,
   output logic              o_flash_sel_en,
   output logic              o_eeprom_sel_en,
   output logic              o_secure_fw_mapped,
   output logic              o_secured,
   output logic              o_opt_write_allowed,
   output logic [15:0]       o_erase_lo,
   output logic [15:0]       o_erase_hi
);
   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_PASS, ST_FAIL} dsg_bc_state_t;

   logic [2:0] pin_raw;
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic       special_s, scan_s, bypass_s;

   assign pin_raw = {i_burnin_bypass, i_scan_mode, i_special_mode};

   // two flops per pin; only the second flop reads the first
   genvar gi;
   generate
      for (gi = 0; gi < $bits(pin_raw); gi++) begin : g_pin_sync
         always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
               pin_meta_reg[gi] <= 1'b0;
               pin_sync_reg[gi] <= 1'b0;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate
   assign special_s = pin_sync_reg[0];
   assign scan_s    = pin_sync_reg[1];
   assign bypass_s  = pin_sync_reg[2];

   // security byte captured during the reset sequence
   logic [7:0] opt_reg;
   logic       loaded_reg;
   logic       special_at_start_reg;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         opt_reg <= DSG_OPT_RESET;
      end else if (i_opt_load && !loaded_reg) begin
         opt_reg <= i_opt_byte;
      end
   end

   // later loads are ignored so a rewrite cannot unsecure before reset
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         loaded_reg <= 1'b0;
      end else if (i_opt_load) begin
         loaded_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         special_at_start_reg <= 1'b0;
      end else if (i_opt_load && !loaded_reg) begin
         special_at_start_reg <= special_s;
      end
   end

   logic sec_field_secure;
   assign sec_field_secure = (opt_reg[1:0] != DSG_SEC_UNSECURED);
   logic key_enabled;
   assign key_enabled = (opt_reg[7:6] == DSG_KEYEN_ENABLED);

   // bypass only while burn-in layer present
   logic secreq;
   assign secreq = sec_field_secure && !bypass_s;

   // software control register
   logic [31:0] ctrl_reg;
   logic [31:0] keycmp_reg;
   logic        wr_en, rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg <= 32'h0;
      end else if (wr_en && paddr == DSG_OFF_CTRL) begin
         ctrl_reg <= pwdata;
      end else begin
         // start and done are one-shot strobes
         ctrl_reg[DSG_CTRL_BC_START] <= 1'b0;
         ctrl_reg[DSG_CTRL_BC_DONE]  <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         keycmp_reg <= 32'h0;
      end else if (wr_en && paddr == DSG_OFF_KEYCMP) begin
         keycmp_reg <= pwdata;
      end
   end

   // blank check sequencing
   dsg_bc_state_t bc_state_reg;
   logic          bc_start_w;
   assign bc_start_w = loaded_reg && special_at_start_reg && secreq;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bc_state_reg <= ST_IDLE;
      end else begin
         case (bc_state_reg)
            ST_IDLE:  if (bc_start_w && ctrl_reg[DSG_CTRL_BC_START]) bc_state_reg <= ST_CHECK;
            ST_CHECK: if (ctrl_reg[DSG_CTRL_BC_DONE]) begin
               bc_state_reg <= ctrl_reg[DSG_CTRL_BC_PASS] ? ST_PASS : ST_FAIL;
            end
            ST_PASS:  bc_state_reg <= ST_PASS;
            ST_FAIL:  bc_state_reg <= ST_FAIL;
            default:  bc_state_reg <= ST_IDLE;
         endcase
      end
   end

   // debug unsecure: blank check pass or backdoor key
   logic key_valid;
   assign key_valid = (keycmp_reg[15:0] != DSG_KEYWORD_ZERO)
                    && (keycmp_reg[15:0] != DSG_KEYWORD_ONES);
   logic unsecure_w;
   // key path only in normal modes
   assign unsecure_w = (bc_state_reg == ST_PASS)
                     || (!special_at_start_reg && key_enabled && key_valid
                         && ctrl_reg[DSG_CTRL_KEY_OK]);

   // secured flag follows loaded byte, not later rewrites
   logic secured_w;
   assign secured_w = !loaded_reg || (secreq && !unsecure_w);

   // stray fetch lockout
   logic stray_reg;
   logic sc_secure_start;
   logic expanded_w;
   assign sc_secure_start = loaded_reg && secreq;
   assign expanded_w = ctrl_reg[DSG_CTRL_EXPAND];
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stray_reg <= 1'b0;
      // stray fetch outside flash space sticks
      end else if (sc_secure_start && expanded_w && i_fetch_valid
                   && (i_pc_top != DSG_PC_FLASH_TOP)) begin
         stray_reg <= 1'b1;
      end
   end

   logic secure_special;
   // before the byte loads, a special mode pin already counts as secured special
   assign secure_special = secured_w && (special_at_start_reg || (!loaded_reg && special_s));
   logic bc_busy;
   assign bc_busy = (bc_state_reg == ST_CHECK)
                  || (special_at_start_reg && secreq && bc_state_reg == ST_IDLE);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dbg_port_active <= 1'b0;
      end else begin
         o_dbg_port_active <= special_s || !secured_w;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dbg_gate <= '0;
      end else begin
         o_dbg_gate.fw_ok <= !bc_busy && !secure_special && !stray_reg
                           && (special_s || !secured_w);
         o_dbg_gate.hw_ok <= !bc_busy && !stray_reg && (special_s || !secured_w);
         // register space only when secured special
         o_dbg_gate.reg_only <= secure_special;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_trace_enable <= 1'b0;
      end else begin
         o_trace_enable <= !secured_w;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_visibility_en <= 1'b0;
      end else begin
         o_visibility_en <= !expanded_w;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pipe_status_en <= 1'b0;
      end else begin
         o_pipe_status_en <= !expanded_w;
      end
   end

   // flash off on stray or scan
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flash_sel_en <= 1'b0;
      end else begin
         o_flash_sel_en <= !stray_reg && !scan_s && loaded_reg;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_eeprom_sel_en <= 1'b0;
      end else begin
         o_eeprom_sel_en <= !stray_reg && !scan_s && loaded_reg;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_secure_fw_mapped <= 1'b0;
      end else begin
         o_secure_fw_mapped <= special_at_start_reg && secreq && !unsecure_w;
      end
   end

   // reset shows secured so trace and firmware debug stay shut before the byte loads; memory selects wait on loaded_reg
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_secured <= 1'b1;
      end else begin
         o_secured <= secured_w;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_opt_write_allowed <= 1'b0;
      end else begin
         o_opt_write_allowed <= !i_sector_protected && ctrl_reg[DSG_CTRL_REPROG]
                              && !secured_w;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_erase_lo <= 16'h0;
         o_erase_hi <= 16'h0;
      end else if (i_nvm_erase_sector && i_nvm_erase_addr >= DSG_SECTOR_LO) begin
         o_erase_lo <= DSG_SECTOR_LO;
         o_erase_hi <= DSG_SECTOR_HI;
      end else begin
         o_erase_lo <= i_nvm_erase_addr;
         o_erase_hi <= i_nvm_erase_addr;
      end
   end

   // apb: zero wait states, unmapped reads zero with error
   logic mapped_w;
   assign mapped_w = (paddr == DSG_OFF_CTRL) || (paddr == DSG_OFF_STATUS)
                   || (paddr == DSG_OFF_OPTSEC) || (paddr == DSG_OFF_KEYCMP);
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= psel && !penable;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= psel && !penable && !mapped_w;
      end
   end

   // read data is fetched in setup so it stands during the access cycle
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h0;
      end else begin
         if (psel && !penable && !pwrite) begin
            case (paddr)
               DSG_OFF_CTRL:   o_prdata <= ctrl_reg;
               DSG_OFF_STATUS: o_prdata <= {26'h0, bc_state_reg, stray_reg,
                                            special_at_start_reg, loaded_reg, secured_w};
               DSG_OFF_OPTSEC: o_prdata <= {24'h0, opt_reg};
               DSG_OFF_KEYCMP: o_prdata <= keycmp_reg;
               default:        o_prdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

// ### dsg_pkg.sv
package dsg_pkg;
   // apb register byte offsets
   localparam logic [7:0] DSG_OFF_CTRL   = 8'h00;
   localparam logic [7:0] DSG_OFF_STATUS = 8'h04;
   localparam logic [7:0] DSG_OFF_OPTSEC = 8'h08;
   localparam logic [7:0] DSG_OFF_KEYCMP = 8'h0C;
   // ctrl bit positions
   localparam int DSG_CTRL_UNSEC    = 0;
   localparam int DSG_CTRL_BC_START = 1;
   localparam int DSG_CTRL_BC_DONE  = 2;
   localparam int DSG_CTRL_BC_PASS  = 3;
   localparam int DSG_CTRL_EXPAND   = 4;
   localparam int DSG_CTRL_KEY_OK   = 5;
   localparam int DSG_CTRL_REPROG   = 6;
   // security field encodings
   localparam logic [1:0] DSG_SEC_UNSECURED = 2'h2;
   localparam logic [1:0] DSG_KEYEN_ENABLED = 2'h2;
   localparam logic [1:0] DSG_SEC_VIRGIN    = 2'h0;
   localparam logic [7:0] DSG_OPT_RESET     = 8'h00;
   // address and key word constants of the flash array
   localparam logic [15:0] DSG_OPT_ADDR      = 16'hFF0F;
   localparam logic [15:0] DSG_KEY_LO        = 16'hFF00;
   localparam logic [15:0] DSG_KEY_HI        = 16'hFF07;
   localparam logic [15:0] DSG_SECTOR_LO     = 16'hFE00;
   localparam logic [15:0] DSG_SECTOR_HI     = 16'hFFFF;
   localparam logic [15:0] DSG_KEYWORD_ZERO  = 16'h0000;
   localparam logic [15:0] DSG_KEYWORD_ONES  = 16'hFFFF;
   localparam logic [1:0]  DSG_PC_FLASH_TOP  = 2'h3;

   typedef struct packed {
      logic hw_cmd;
      logic fw_cmd;
      logic [15:0] addr;
   } dsg_dbg_req_t;

   typedef struct packed {
      logic fw_ok;
      logic hw_ok;
      logic reg_only;
   } dsg_dbg_gate_t;
endpackage

// ### dsg_dbg_host.sv
module dsg_dbg_host
   import dsg_pkg::*;
(
   input  wire logic   i_clk_sys,
   input  wire logic   i_rst_n,
   output dsg_dbg_req_t o_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // a host keeps each command up for a few cycles, then picks another
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_req <= '0;
      end else if ($urandom % 4 == 0) begin
         o_req.hw_cmd <= 1'($urandom);
         o_req.fw_cmd <= 1'($urandom);
         o_req.addr   <= 16'($urandom);
      end
   end
endmodule

// ### dsg_security_gate_assertions.sv
module dsg_security_gate_chk
   import dsg_pkg::*;
(
   input wire logic          i_clk_sys,
   input wire logic          i_rst_n,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic [7:0]    paddr,
   input wire logic          o_pready,
   input wire logic          o_pslverr,
   input wire logic          i_scan_mode,
   input wire logic          i_sector_protected,
   input wire logic          i_nvm_erase_sector,
   input wire logic [15:0]   i_nvm_erase_addr,
   input wire dsg_dbg_gate_t o_dbg_gate,
   input wire logic          o_secured,
   input wire logic          o_trace_enable,
   input wire logic          o_flash_sel_en,
   input wire logic          o_eeprom_sel_en,
   input wire logic          o_opt_write_allowed,
   input wire logic [15:0]   o_erase_lo,
   input wire logic [15:0]   o_erase_hi
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   AST_APB_ZERO_WAIT: assert property ((psel && !penable) |=> o_pready)
      else $error("pready missing in access cycle");
   AST_APB_READY_SINGLE: assert property (o_pready |=> !o_pready)
      else $error("pready held two cycles");
   AST_APB_UNMAPPED: assert property ((o_pready && paddr > 8'h0C) |-> o_pslverr)
      else $error("unmapped access not refused");
   AST_FW_NEEDS_UNSEC: assert property (o_dbg_gate.fw_ok |-> !o_secured)
      else $error("firmware commands open while secured");
   AST_SECURED_REG_ONLY: assert property ((o_secured && o_dbg_gate.hw_ok) |-> o_dbg_gate.reg_only)
      else $error("secured debug not confined to registers");
   AST_TRACE_OFF: assert property (o_secured |-> !o_trace_enable)
      else $error("tracing while secured");
   AST_SCAN_BLOCK: assert property (i_scan_mode [*4] |=> !o_flash_sel_en && !o_eeprom_sel_en)
      else $error("memory selects open in scan");
   AST_ERASE_SECTOR: assert property ((i_nvm_erase_sector && i_nvm_erase_addr >= 16'hFE00)
      [*2] |-> o_erase_lo == 16'hFE00 && o_erase_hi == 16'hFFFF)
      else $error("erase range not whole sector");
   AST_OPT_PROTECTED: assert property (i_sector_protected [*2] |-> !o_opt_write_allowed)
      else $error("security byte writable in protected sector");
endmodule
bind dsg_security_gate dsg_security_gate_chk u_chk (.i_clk_sys, .i_rst_n, .psel, .penable,
   .paddr, .o_pready, .o_pslverr, .i_scan_mode, .i_sector_protected, .i_nvm_erase_sector,
   .i_nvm_erase_addr, .o_dbg_gate, .o_secured, .o_trace_enable, .o_flash_sel_en,
   .o_eeprom_sel_en, .o_opt_write_allowed, .o_erase_lo, .o_erase_hi);

// ### device_security_gate_test.sv
module device_security_gate_test
   import dsg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0, o_pready, o_pslverr;
   logic [7:0] paddr = 0, i_opt_byte = 0;
   logic [31:0] pwdata = 0, o_prdata, q;
   logic i_special_mode = 0, i_scan_mode = 0, i_opt_load = 0, i_fetch_valid = 0;
   logic i_sector_protected = 0, i_nvm_erase_sector = 0, err;
   logic [1:0] i_pc_top = 2'h3;
   logic [15:0] i_fetch_addr = 0, i_nvm_erase_addr = 0, o_erase_lo, o_erase_hi;
   logic o_dbg_port_active, o_trace_enable, o_visibility_en, o_pipe_status_en, o_flash_sel_en;
   logic o_eeprom_sel_en, o_secure_fw_mapped, o_secured, o_opt_write_allowed;
   dsg_dbg_req_t i_dbg_req;
   dsg_dbg_gate_t o_dbg_gate;
   int fail_count = 0, total_checks = 0;
   logic [7:0] b;
   always #2 i_clk_sys = ~i_clk_sys;
   dsg_security_gate u_dut (.i_clk_sys, .i_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .o_pready, .o_prdata, .o_pslverr, .i_special_mode, .i_scan_mode, .i_burnin_bypass(1'b0),
      .i_opt_load, .i_opt_byte, .i_pc_top, .i_fetch_addr, .i_fetch_valid, .i_sector_protected,
      .i_dbg_req, .i_nvm_erase_addr, .i_nvm_erase_sector, .o_dbg_gate, .o_dbg_port_active,
      .o_trace_enable, .o_visibility_en, .o_pipe_status_en, .o_flash_sel_en, .o_eeprom_sel_en,
      .o_secure_fw_mapped, .o_secured, .o_opt_write_allowed, .o_erase_lo, .o_erase_hi);
   dsg_dbg_host u_host (.i_clk_sys, .i_rst_n, .o_req(i_dbg_req));
   always @(posedge i_clk_sys) begin
      i_sector_protected <= 1'($urandom);
      i_fetch_addr       <= 16'($urandom);
   end
   task tally_and_finish();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1;
      do @(posedge i_clk_sys); while (o_pready !== 1'b1 && ++n < 20);
      if (n >= 20) fail_count++;
      q = o_prdata;
      err = o_pslverr;
      psel <= 0; penable <= 0;
      @(posedge i_clk_sys);
   endtask
   task rst(input logic sp, input logic [7:0] ob);
      i_rst_n <= 0; i_special_mode <= sp;
      repeat (6) @(posedge i_clk_sys);
      chk(o_secured, 1);
      i_rst_n <= 1;
      repeat (3) @(posedge i_clk_sys);
      i_opt_load <= 1; i_opt_byte <= ob;
      @(posedge i_clk_sys);
      i_opt_load <= 0;
      repeat (3) @(posedge i_clk_sys);
   endtask
   function logic exp_secured(input logic [1:0] f);
      return f != 2'h2;
   endfunction
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h86c7));
      for (int k = 0; k < 4; k++) begin
         b = {(k == 0) ? DSG_KEYEN_ENABLED : 2'($urandom), 4'($urandom), 2'(k)};
         rst(0, b);
         // field decode, virgin 00 stays secured
         chk(o_secured, exp_secured(b[1:0]));
         apb(0, DSG_OFF_STATUS, 0);
         chk(q[0], exp_secured(b[1:0]));
         apb(0, DSG_OFF_OPTSEC, 0);
         chk(q, {24'h0, b});
         apb(0, 8'h10 + 8'(4 * ($urandom % 8)), 0);
         chk({err, q}, {1'b1, 32'h0});
         // key words avoid all zeros and all ones
         apb(1, DSG_OFF_KEYCMP, 32'h1 + $urandom % 32'hFFFD);
         apb(1, DSG_OFF_CTRL, 32'(1 << DSG_CTRL_KEY_OK));
         repeat (2) @(posedge i_clk_sys);
         chk(o_secured, exp_secured(b[1:0]) && b[7:6] != DSG_KEYEN_ENABLED);
         i_nvm_erase_sector <= 1; i_nvm_erase_addr <= 16'hFE00 | 16'($urandom % 512);
         repeat (3) @(posedge i_clk_sys);
         chk({o_erase_lo, o_erase_hi}, 32'hFE00FFFF);
         i_nvm_erase_sector <= 0;
         if (k == 1) begin
            apb(1, DSG_OFF_CTRL, 32'(1 << DSG_CTRL_EXPAND));
            repeat (2) @(posedge i_clk_sys);
            chk({o_visibility_en, o_pipe_status_en}, 0);
            i_fetch_valid <= 1; i_pc_top <= 2'($urandom % 3);
            @(posedge i_clk_sys);
            i_pc_top <= 2'h3;
            repeat (4) @(posedge i_clk_sys);
            chk({o_flash_sel_en, o_eeprom_sel_en}, 0);
            i_fetch_valid <= 0;
         end
         if (k == 3) begin
            i_scan_mode <= 1;
            repeat (6) @(posedge i_clk_sys);
            chk({o_flash_sel_en, o_eeprom_sel_en}, 0);
            i_scan_mode <= 0;
         end
      end
      for (int p = 0; p < 2; p++) begin
         rst(1, DSG_OPT_RESET);
         chk(o_dbg_port_active, 1);
         chk({o_dbg_gate.fw_ok, o_dbg_gate.hw_ok}, 0);
         apb(1, DSG_OFF_CTRL, 32'h2);
         apb(1, DSG_OFF_CTRL, 32'h4 | 32'(p << 3));
         repeat (3) @(posedge i_clk_sys);
         if (p == 1) chk(o_dbg_gate.fw_ok, 1);
         else chk(o_dbg_gate, 3'b011);
         chk(o_trace_enable & o_secured, 0);
      end
      tally_and_finish();
   end
endmodule
